/* File: imba_defs.vh */
`ifndef IMBA_DEFS_VH
`define IMBA_DEFS_VH

// widths
`define IMBA_INT_ADDR_W 24
`define IMBA_EXT_ADDR_W 22
`define IMBA_PAGE_W 8
`define IMBA_OFFS_W 16
`define IMBA_PS_DATA_W 24
`define IMBA_DS_DATA_W 16
`define IMBA_XCH_W 8

// exchange register
`define IMBA_XCH_RESET 8'h00
`define IMBA_XCH_LSB 0

// page source selectors
`define IMBA_PG_FIRST 2'h0
`define IMBA_PG_SECOND 2'h1
`define IMBA_PG_IJUMP 2'h2
`define IMBA_PG_IO 2'h3

// external port owner codes
`define IMBA_OWN_NONE 2'h0
`define IMBA_OWN_DS 2'h1
`define IMBA_OWN_PS 2'h2
`define IMBA_OWN_IO 2'h3

// longest time a core bus may be held off by the dma path, in cycles
`define IMBA_DMA_HOLD_MAX 4

`endif

/* File: imba_exch_reg.v */
`timescale 1ns/1ps
module imba_exch_reg #(
    parameter W = 8
) (
    core_clk,
    reset,
    ld_en,
    ld_val,
    q
);
    input wire core_clk;
    input wire reset;
    input wire ld_en;
    input wire [W-1:0] ld_val;
    output reg [W-1:0] q;

    always @(posedge core_clk) begin
        if (reset) begin
            q <= {W{1'b0}};
        end else if (ld_en) begin
            q <= ld_val;
        end
    end
endmodule // imba_exch_reg

/* File: imba_arbiter.v */
// Notes on behaviour
// - same-block core pair costs one stall; data side served, program side next cycle.
// - dual-data access is single-cycle only when words sit in different blocks.
// - fetch collision uses cached instruction, else extra cycle and cache fill.
// - fixed priority data side, then program side, then io processor.
// - dma never holds either core bus off longer than four cycles.
// - io non-dma goes over data side; dma uses its own memory port path.
// - only 22 low address bits leave the chip.
// - upper eight address bits come from the requester's page register.
// - program side data lines 24 bits, data side 16 bits.
// - program, data and io buses multiplex onto one external data and address bus.
// - address units drive both buses; sequencer drives only program side.
// - program-memory data read puts upper 16 in register, low 8 in exchange.
// - register write to internal program memory appends exchange byte as low eight bits; external writes drive the register alone.
// - explicit move into exchange keeps only low eight data side bits.
// - explicit exchange read returns its byte with upper eight bits zero.
// - dual read feeds upper 16 program side bits to Y registers directly.
// - exchange register is in register group three, usable single-cycle.
// - core and dma each may access a block; dma waits on same-block contention.
`timescale 1ns/1ps
`include "imba_defs.vh"
module imba_arbiter #(
    parameter BLK_W = 2,
    parameter HOLD_MAX = `IMBA_DMA_HOLD_MAX
) (
    input wire core_clk,
    input wire reset,
    // data side bus request
    input wire ds_req,
    input wire ds_we,
    input wire ds_ext,
    input wire ds_io,
    input wire ds_src_io,
    input wire ds_addr_unit,
    input wire [`IMBA_OFFS_W-1:0] ds_offs,
    input wire [BLK_W-1:0] ds_blk,
    input wire [`IMBA_DS_DATA_W-1:0] ds_wdata,
    output wire ds_gnt,
    output reg [`IMBA_DS_DATA_W-1:0] ds_rdata_q,
    // program side bus request
    input wire ps_req,
    input wire ps_we,
    input wire ps_ext,
    input wire ps_fetch,
    input wire ps_ijump,
    input wire ps_addr_unit,
    input wire ps_data_rd,
    input wire [`IMBA_OFFS_W-1:0] ps_offs,
    input wire [BLK_W-1:0] ps_blk,
    input wire [`IMBA_DS_DATA_W-1:0] ps_wreg,
    input wire cache_hit,
    output wire ps_gnt,
    output wire cache_fill,
    output reg [`IMBA_PS_DATA_W-1:0] ps_rdata_q,
    output reg [`IMBA_DS_DATA_W-1:0] ps_reg_data_q,
    output reg [`IMBA_DS_DATA_W-1:0] y_reg_data_q,
    output reg y_reg_valid_q,
    // io processor dma path
    input wire dma_req,
    input wire dma_we,
    input wire dma_ext,
    input wire [`IMBA_INT_ADDR_W-1:0] dma_addr,
    input wire [BLK_W-1:0] dma_blk,
    input wire [`IMBA_DS_DATA_W-1:0] dma_wdata,
    output wire dma_gnt,
    output reg [`IMBA_DS_DATA_W-1:0] dma_rdata_q,
    // page registers
    input wire [`IMBA_PAGE_W-1:0] first_addr_unit_page,
    input wire [`IMBA_PAGE_W-1:0] second_addr_unit_page,
    input wire [`IMBA_PAGE_W-1:0] indirect_jump_page,
    input wire [`IMBA_PAGE_W-1:0] io_space_page,
    // register group three access to the exchange byte
    input wire xch_wr,
    input wire xch_rd,
    input wire [`IMBA_DS_DATA_W-1:0] xch_wdata,
    output reg [`IMBA_DS_DATA_W-1:0] xch_rdata_q,
    output wire [`IMBA_XCH_W-1:0] bus_exchange_low_byte,
    // internal memory port, one request per block per cycle, except that a drained program side access shares the block with the data side
    output reg mem_ds_en,
    output reg mem_ps_en,
    output reg mem_dma_en,
    input wire [`IMBA_PS_DATA_W-1:0] mem_ps_rdata,
    input wire [`IMBA_DS_DATA_W-1:0] mem_ds_rdata,
    input wire [`IMBA_DS_DATA_W-1:0] mem_dma_rdata,
    output wire [`IMBA_PS_DATA_W-1:0] mem_ps_wdata,
    // external port
    output reg [`IMBA_EXT_ADDR_W-1:0] ext_address_pins,
    output reg [`IMBA_DS_DATA_W-1:0] ext_data_out,
    output reg ext_data_oe_n,
    input wire [`IMBA_DS_DATA_W-1:0] ext_data_pins,
    output reg [1:0] ext_owner_q
);
    ////////////////////////////////////////////////////////////////////////////
    // addresses
    wire [`IMBA_PAGE_W-1:0] ds_page;
    wire [`IMBA_PAGE_W-1:0] ps_page;
    wire [`IMBA_INT_ADDR_W-1:0] ds_addr;
    wire [`IMBA_INT_ADDR_W-1:0] ps_addr;

    // io space or address unit page picks the data side page
    assign ds_page = ds_io ? io_space_page :
        (ds_addr_unit ? second_addr_unit_page : first_addr_unit_page);
    // sequencer only uses the program side: indirect jump page, else unit page
    assign ps_page = ps_ijump ? indirect_jump_page :
        (ps_addr_unit ? second_addr_unit_page : first_addr_unit_page);
    assign ds_addr = {ds_page, ds_offs};
    assign ps_addr = {ps_page, ps_offs};

    ////////////////////////////////////////////////////////////////////////////
    // core arbitration
    reg ps_wait_q;
    reg [2:0] hold_cnt_q;
    wire blk_clash;
    wire ps_int_ok;
    wire int_ps_gnt;
    wire ext_ds;
    wire ext_ps;
    wire ext_dma;

    assign blk_clash = ds_req & ps_req & ~ds_ext & ~ps_ext & (ds_blk == ps_blk);
    // a fetch that hits the cache is served there and needs no memory slot
    assign ps_int_ok = ~blk_clash | (ps_fetch & cache_hit) | ps_wait_q;
    assign int_ps_gnt = ps_req & ~ps_ext & ps_int_ok;
    assign cache_fill = blk_clash & ps_fetch & ~cache_hit & ~ps_wait_q;

    // external port: one owner at a time
    assign ext_ds = ds_req & ds_ext;
    assign ext_ps = ps_req & ps_ext & ~ext_ds;
    assign ext_dma = dma_req & dma_ext & ~ext_ds & ~ext_ps & ~(ds_req & ds_src_io);
    assign ds_gnt = ds_req & (~ds_ext | ext_ds);
    assign ps_gnt = ps_ext ? (ps_req & ext_ps) : int_ps_gnt;

    // held program side access drains on the next cycle, ahead of new clashes
    always @(posedge core_clk) begin
        if (reset) begin
            ps_wait_q <= 1'b0;
        end else begin
            ps_wait_q <= blk_clash & ~ps_int_ok & ~(ps_fetch & cache_hit);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // dma cycle stealing on its own port
    wire dma_blk_busy;
    wire dma_int_ok;
    wire hold_out;

    assign dma_blk_busy = (ds_req & ~ds_ext & (ds_blk == dma_blk)) |
        (int_ps_gnt & (ps_blk == dma_blk));
    // after the bounded hold the dma stands aside for one cycle
    localparam [2:0] HOLD_LIM = HOLD_MAX;
    assign hold_out = (hold_cnt_q == HOLD_LIM);
    assign dma_int_ok = dma_req & ~dma_ext & ~dma_blk_busy & ~hold_out;
    assign dma_gnt = dma_int_ok | (ext_dma & ~hold_out);

    // counts consecutive dma grants while a core request is pending
    always @(posedge core_clk) begin
        if (reset) begin
            hold_cnt_q <= 3'h0;
        end else if (dma_gnt & (ds_req | ps_req)) begin
            hold_cnt_q <= hold_cnt_q + 3'h1;
        end else begin
            hold_cnt_q <= 3'h0;
        end
    end

    always @* begin
        mem_ds_en = ds_gnt & ~ds_ext;
        mem_ps_en = int_ps_gnt & ~(ps_fetch & cache_hit);
        mem_dma_en = dma_int_ok;
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus exchange byte
    wire xch_ld;
    wire [`IMBA_XCH_W-1:0] xch_val;
    wire ps_data_read;
    wire [`IMBA_PS_DATA_W-1:0] ps_rd_word;

    assign ps_data_read = int_ps_gnt & ps_data_rd & ~ps_we & ~ps_fetch;
    assign ps_rd_word = ps_ext ? {ext_data_pins, {`IMBA_XCH_W{1'b0}}} : mem_ps_rdata;
    assign xch_ld = xch_wr | (ps_data_read & ~xch_wr) | (ps_gnt & ps_ext & ps_data_rd);
    // explicit move wins; only its low byte survives
    assign xch_val = xch_wr ? xch_wdata[`IMBA_XCH_W-1:0] :
        ps_rd_word[`IMBA_XCH_W-1:0];

    imba_exch_reg #(
        .W(`IMBA_XCH_W)
    ) u_xch (
        .core_clk(core_clk),
        .reset(reset),
        .ld_en(xch_ld),
        .ld_val(xch_val),
        .q(bus_exchange_low_byte)
    );

    // register value in the top, exchange byte in the bottom of the word
    assign mem_ps_wdata = {ps_wreg, bus_exchange_low_byte};

    ////////////////////////////////////////////////////////////////////////////
    // read data
    always @(posedge core_clk) begin
        if (reset) begin
            ds_rdata_q <= 16'h0000;
            ps_rdata_q <= 24'h000000;
            ps_reg_data_q <= 16'h0000;
            y_reg_data_q <= 16'h0000;
            y_reg_valid_q <= 1'b0;
            dma_rdata_q <= 16'h0000;
            xch_rdata_q <= 16'h0000;
        end else begin
            if (ds_gnt & ~ds_we) begin
                ds_rdata_q <= ds_ext ? ext_data_pins : mem_ds_rdata;
            end
            if (ps_gnt & ~ps_we) begin
                ps_rdata_q <= ps_rd_word;
                ps_reg_data_q <= ps_rd_word[`IMBA_PS_DATA_W-1:`IMBA_XCH_W];
            end
            // dual read: direct path to the Y registers, though the exchange byte still loads
            y_reg_valid_q <= ps_data_read & ds_gnt & ~ds_we;
            if (ps_data_read & ds_gnt & ~ds_we) begin
                y_reg_data_q <= mem_ps_rdata[`IMBA_PS_DATA_W-1:`IMBA_XCH_W];
            end
            if (dma_gnt & ~dma_we) begin
                dma_rdata_q <= dma_ext ? ext_data_pins : mem_dma_rdata;
            end
            if (xch_rd) begin
                xch_rdata_q <= {8'h00, bus_exchange_low_byte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // external port multiplexing
    reg [`IMBA_EXT_ADDR_W-1:0] ext_addr_d;
    reg [`IMBA_DS_DATA_W-1:0] ext_data_d;
    reg ext_oe_n_d;
    reg [1:0] owner_d;

    always @* begin
        ext_addr_d = ext_address_pins;
        ext_data_d = ext_data_out;
        ext_oe_n_d = 1'b1;
        owner_d = `IMBA_OWN_NONE;
        if (ext_ds) begin
            ext_addr_d = ds_addr[`IMBA_EXT_ADDR_W-1:0];
            ext_data_d = ds_wdata;
            ext_oe_n_d = ~ds_we;
            owner_d = `IMBA_OWN_DS;
        end else if (ext_ps) begin
            ext_addr_d = ps_addr[`IMBA_EXT_ADDR_W-1:0];
            ext_data_d = ps_wreg;
            ext_oe_n_d = ~ps_we;
            owner_d = `IMBA_OWN_PS;
        end else if (ext_dma & ~hold_out) begin
            ext_addr_d = dma_addr[`IMBA_EXT_ADDR_W-1:0];
            ext_data_d = dma_wdata;
            ext_oe_n_d = ~dma_we;
            owner_d = `IMBA_OWN_IO;
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            ext_address_pins <= 22'h000000;
            ext_data_out <= 16'h0000;
            ext_data_oe_n <= 1'b1;
            ext_owner_q <= `IMBA_OWN_NONE;
        end else begin
            ext_address_pins <= ext_addr_d;
            ext_data_out <= ext_data_d;
            ext_data_oe_n <= ext_oe_n_d;
            ext_owner_q <= owner_d;
        end
    end
endmodule // imba_arbiter

/* File: imba_mem_model.sv */
`timescale 1ns/1ps
module imba_mem_model (
    input wire core_clk,
    input wire mem_ps_en,
    input wire mem_ds_en,
    input wire mem_dma_en,
    input wire ps_we,
    input wire [15:0] ps_offs,
    input wire [15:0] ds_offs,
    input wire [23:0] dma_addr,
    input wire [23:0] mem_ps_wdata,
    input wire [15:0] ext_data_out,
    input wire ext_data_oe_n,
    output logic [23:0] mem_ps_rdata,
    output logic [15:0] mem_ds_rdata,
    output logic [15:0] mem_dma_rdata,
    output logic [15:0] ext_data_pins
);
    logic [23:0] pmem [0:15];
    logic tog_q = 1'h0;
    wire [23:0] junk = tog_q ? 24'hA5A55A : 24'h5A5AA5;
    initial for (int i = 0; i < 16; i++) pmem[i] = 24'hC3A500 + i;
    // unselected ports show a changing pattern so stale data cannot pass
    always @(posedge core_clk) begin
        tog_q <= ~tog_q;
        if (mem_ps_en && ps_we) pmem[ps_offs[3:0]] <= mem_ps_wdata;
    end
    assign mem_ps_rdata = mem_ps_en ? pmem[ps_offs[3:0]] : junk;
    assign mem_ds_rdata = mem_ds_en ? ds_offs ^ 16'h0F0F : junk[15:0];
    assign mem_dma_rdata = mem_dma_en ? dma_addr[15:0] ^ 16'hF00F : junk[15:0];
    assign ext_data_pins = ext_data_oe_n ? 16'h6D21 : ext_data_out;
endmodule // imba_mem_model

/* File: imba_asserts.sv */
`timescale 1ns/1ps
module imba_asserts #(parameter BLK_W = 2, parameter HOLD_MAX = 4) (
    input wire core_clk, input wire reset,
    input wire ds_req, input wire ds_ext, input wire ds_io, input wire ds_addr_unit,
    input wire [15:0] ds_offs, input wire [BLK_W-1:0] ds_blk, input wire ds_gnt,
    input wire ps_req, input wire ps_ext, input wire ps_fetch, input wire ps_data_rd,
    input wire [BLK_W-1:0] ps_blk, input wire [15:0] ps_wreg, input wire cache_hit,
    input wire ps_gnt, input wire cache_fill, input wire [15:0] ps_reg_data_q,
    input wire dma_req, input wire dma_ext, input wire [BLK_W-1:0] dma_blk, input wire dma_gnt,
    input wire [7:0] first_addr_unit_page, input wire xch_wr, input wire xch_rd,
    input wire [15:0] xch_wdata, input wire [15:0] xch_rdata_q,
    input wire [7:0] bus_exchange_low_byte, input wire [23:0] mem_ps_rdata,
    input wire [23:0] mem_ps_wdata, input wire [21:0] ext_address_pins,
    input wire [1:0] ext_owner_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    wire clash = ds_req && ps_req && !ds_ext && !ps_ext && ds_blk == ps_blk;
    wire dma_hit = (ds_req && !ds_ext && ds_blk == dma_blk) || (ps_req && !ps_ext && ps_blk == dma_blk);
    logic [2:0] hold_q;
    logic wait_q;
    // a refused program side access is served next cycle even if the clash persists
    always @(posedge core_clk) wait_q <= !reset && clash && !ps_gnt;
    // counts dma grants taken while a core bus waits
    always @(posedge core_clk) hold_q <= (reset || !(dma_gnt && (ds_req || ps_req))) ? 3'h0 : hold_q + 3'h1;
    ds_first_a: assert property (ds_req |-> ds_gnt) else $error("data side not granted");
    clash_stall_a: assert property (clash && !wait_q && !(ps_fetch && cache_hit) |->
        !ps_gnt ##1 (ps_gnt || !ps_req))
        else $error("same block stall wrong");
    diff_blk_a: assert property (ds_req && ps_req && !ds_ext && !ps_ext && ds_blk != ps_blk |-> ps_gnt)
        else $error("dual access stalled");
    hit_single_a: assert property (clash && ps_fetch && cache_hit |-> ps_gnt && !cache_fill)
        else $error("cached fetch stalled");
    miss_fill_a: assert property (clash && !wait_q && ps_fetch && !cache_hit |-> cache_fill)
        else $error("no fill");
    dma_wait_a: assert property (dma_req && !dma_ext && dma_hit |-> !dma_gnt) else $error("dma won");
    dma_hold_a: assert property (hold_q <= HOLD_MAX) else $error("core held off too long");
    xch_move_a: assert property (xch_wr |=> bus_exchange_low_byte == $past(xch_wdata[7:0]))
        else $error("exchange load wrong");
    xch_read_a: assert property (xch_rd && !xch_wr |=> xch_rdata_q == {8'h00, $past(bus_exchange_low_byte)})
        else $error("exchange read wrong");
    pm_write_a: assert property (mem_ps_wdata == {ps_wreg, bus_exchange_low_byte})
        else $error("program word packing wrong");
    pm_read_a: assert property (ps_gnt && ps_data_rd && !ps_ext && !xch_wr |=>
        ps_reg_data_q == $past(mem_ps_rdata[23:8]) && bus_exchange_low_byte == $past(mem_ps_rdata[7:0]))
        else $error("program data split wrong");
    ext_page_a: assert property (ds_gnt && ds_ext && !ds_io && !ds_addr_unit |=>
        ext_address_pins == {$past(first_addr_unit_page[5:0]), $past(ds_offs)} && ext_owner_q == 2'h1)
        else $error("external address wrong");
    cover property (clash);
    cover property (clash && ps_fetch && cache_hit);
    cover property (dma_req && dma_hit);
endmodule // imba_asserts
bind imba_arbiter imba_asserts #(.BLK_W(BLK_W), .HOLD_MAX(HOLD_MAX)) chk_i (.*);

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'h0, reset = 1'h1, cache_hit = 1'h0, xch_wr = 1'h0, xch_rd = 1'h0;
    logic ds_req = 1'h0, ds_we = 1'h0, ds_ext = 1'h0, ds_io = 1'h0, ds_src_io = 1'h0, ds_addr_unit = 1'h0;
    logic ps_req = 1'h0, ps_we = 1'h0, ps_ext = 1'h0, ps_fetch = 1'h0, ps_ijump = 1'h0;
    logic ps_addr_unit = 1'h0, ps_data_rd = 1'h0, dma_req = 1'h0, dma_we = 1'h0, dma_ext = 1'h0;
    logic [15:0] ds_offs = 16'h0, ds_wdata = 16'h0, ps_offs = 16'h3, ps_wreg = 16'h0;
    logic [15:0] dma_wdata = 16'h0, xch_wdata = 16'h0;
    logic [1:0] ds_blk = 2'h1, ps_blk = 2'h1, dma_blk = 2'h1;
    logic [23:0] dma_addr = 24'h000042;
    logic [7:0] first_addr_unit_page = 8'hC1, second_addr_unit_page = 8'h82;
    logic [7:0] indirect_jump_page = 8'h07, io_space_page = 8'h43;
    wire ds_gnt, ps_gnt, cache_fill, y_reg_valid_q, dma_gnt, mem_ds_en, mem_ps_en, mem_dma_en;
    wire ext_data_oe_n;
    wire [15:0] ds_rdata_q, ps_reg_data_q, y_reg_data_q, dma_rdata_q, xch_rdata_q;
    wire [15:0] mem_ds_rdata, mem_dma_rdata, ext_data_out, ext_data_pins;
    wire [23:0] ps_rdata_q, mem_ps_rdata, mem_ps_wdata;
    wire [7:0] bus_exchange_low_byte;
    wire [21:0] ext_address_pins;
    wire [1:0] ext_owner_q;
    int num_errors = 0, checks = 0;
    imba_arbiter #(.BLK_W(2), .HOLD_MAX(4)) uut (.*);
    imba_mem_model mem_i (.*);
    always #5 core_clk = ~core_clk;
    task chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task end_sim;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task cyc;
        @(negedge core_clk);
    endtask
    initial begin
        #20000;
        num_errors++;
        end_sim;
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'h0;
        cyc;
        chk("oe_n", 1'h1, ext_data_oe_n);
        @(posedge core_clk) {ds_req, ps_req, ps_data_rd} <= 3'h7;
        cyc;
        chk("ds_gnt", 1'h1, ds_gnt);
        chk("ps_gnt stall", 1'h0, ps_gnt);
        @(posedge core_clk) ds_req <= 1'h0;
        cyc;
        chk("ps_gnt retry", 1'h1, ps_gnt);
        @(posedge core_clk) ps_req <= 1'h0;
        cyc;
        chk("ps_reg_data", 16'hC3A5, ps_reg_data_q);
        chk("xch auto", 8'h03, bus_exchange_low_byte);
        @(posedge core_clk) {ds_req, ps_req, ps_blk} <= 4'hE;
        cyc;
        chk("dual gnt", 1'h1, ps_gnt);
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk) {ds_req, ps_blk, ps_fetch, ps_data_rd, cache_hit} <= {5'h16, i[0]};
            cyc;
            if (i == 0) begin
                chk("y valid", 1'h1, y_reg_valid_q);
                chk("y data", 16'hC3A5, y_reg_data_q);
                chk("ds rdata", 16'h0F0F, ds_rdata_q);
            end
            chk("fetch gnt", i[0], ps_gnt);
            chk("cache fill", !i[0], cache_fill);
            @(posedge core_clk) ds_req <= 1'h0;
        end
        @(posedge core_clk) {ds_req, ps_req, ps_fetch, xch_wr, xch_wdata} <= {4'h1, 16'hBEEF};
        @(posedge core_clk) {xch_wr, xch_rd} <= 2'h1;
        @(posedge core_clk) {xch_rd, ps_req, ps_we, ps_wreg, ps_offs} <= {3'h3, 32'h13570005};
        cyc;
        chk("xch read", 16'h00EF, xch_rdata_q);
        chk("xch move", 8'hEF, bus_exchange_low_byte);
        chk("pm word", 24'h1357EF, mem_ps_wdata);
        @(posedge core_clk) {ps_we, ps_data_rd} <= 2'h1;
        @(posedge core_clk) {ps_req, ps_data_rd} <= 2'h0;
        cyc;
        chk("pm read", 24'h1357EF, ps_rdata_q);
        @(posedge core_clk) {ds_req, dma_req} <= 2'h3;
        cyc;
        chk("dma wait", 1'h0, dma_gnt);
        @(posedge core_clk) ds_req <= 1'h0;
        cyc;
        chk("dma gnt", 1'h1, dma_gnt);
        chk("mem dma en", 1'h1, mem_dma_en);
        @(posedge core_clk) dma_req <= 1'h0;
        cyc;
        chk("dma data", 16'hF04D, dma_rdata_q);
        @(posedge core_clk) {ds_req, ps_req, dma_req, ds_ext, ps_ext, dma_ext} <= 6'h3F;
        cyc;
        chk("ext ps", 1'h0, ps_gnt);
        chk("ext io", 1'h0, dma_gnt);
        @(posedge core_clk) ds_req <= 1'h0;
        cyc;
        chk("ext ps next", 1'h1, ps_gnt);
        @(posedge core_clk) {ps_req, ps_ext, dma_ext} <= 3'h0;
        @(posedge core_clk) dma_req <= 1'h0;
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk) {ds_req, ds_io, ds_addr_unit, ds_offs} <= {1'h1, i[1:0], 16'h1234};
            @(posedge core_clk) ds_req <= 1'h0;
            cyc;
            chk("ext addr", {i == 0 ? 6'h01 : i == 1 ? 6'h02 : 6'h03, 16'h1234}, ext_address_pins);
            chk("ext owner", 2'h1, ext_owner_q);
        end
        end_sim;
    end
endmodule // testbench
